// *** comfsm_pkg.sv ***
package comfsm_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_BKPT = 8'h08;
    localparam logic [7:0] ADDR_CYCLES = 8'h0C;

    // CTRL bits (write 1 = one-cycle command, except bit 5 which is stored)
    localparam int CTRL_RUN = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_STEP = 2;
    localparam int CTRL_RESUME = 3;
    localparam int CTRL_OVERALL_RESET = 4;
    localparam int CTRL_COLD_PRESENT = 5;

    // STATUS fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_LOCK = 2;
    localparam int STAT_WDOG_LATCH = 3;
    localparam int STAT_YELLOW = 4;
    localparam int STAT_GREEN = 5;
    localparam int STAT_RED = 6;
    localparam int STAT_STEP_REJ = 7;
    localparam int STAT_COLD_PRESENT = 8;

    localparam int BKPT_MAX = 3;
    localparam int BKPT_STEP_LIMIT = 2;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint CLK_HZ = 100_000_000;
    localparam longint GREEN_MIN_MS = 3000;
    localparam longint GREEN_MIN_CYC = GREEN_MIN_MS * (CLK_HZ / 1000);
    localparam longint HOLD_BLINK_HZ = 1;
    localparam longint HOLD_HALF_CYC = CLK_HZ / (2 * HOLD_BLINK_HZ);
    localparam longint PON_BLINK_MS = 2000;
    localparam longint PON_BLINK_CYC = PON_BLINK_MS * (CLK_HZ / 1000);
    localparam longint FAST_HALF_MS = 250;
    localparam longint FAST_HALF_CYC = FAST_HALF_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_STARTUP,
        MODE_RUN,
        MODE_HOLD
    } comfsm_mode_t;
endpackage : comfsm_pkg

// *** comfsm_top.sv ***
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - Four modes: stop, startup, run, hold
// RULE_02 - Stop keeps program sequencer idle
// RULE_03 - Stop retains counters, timers, images
// RULE_04 - Stop asserts command output lock
// RULE_05 - Stop lights yellow steadily
// RULE_06 - After power-on yellow blinks briefly
// RULE_07 - Stop to run passes warm start
// RULE_08 - Warm start has no time supervision
// RULE_09 - Startup keeps output lock asserted
// RULE_10 - Green blinks at least three seconds
// RULE_11 - Run lights green steadily
// RULE_12 - Watchdog stop needs cold start routine
// RULE_13 - Overall reset or reload clears watchdog
// RULE_14 - Run executes main routine each cycle
// RULE_15 - Run keeps timers active, refreshes image; code clears and reads the image only once, on entering run
// RULE_16 - Run releases command output lock
// RULE_17 - At most three breakpoints defined
// RULE_18 - Breakpoint hit enters hold; step/resume
// RULE_19 - Hold: red on, green 1 Hz
// RULE_20 - Hold freezes program, timers; clock runs
// RULE_21 - Hold locks outputs, keeps connections
// RULE_22 - Over two breakpoints rejects single step
// RULE_23 - Cycle: clear outputs, read inputs, main; code enables main with the clear, one cycle before the input read
// RULE_24 - Reset to stop; change on events only
module comfsm_top #(
    parameter longint GREEN_MIN_CYCLES = comfsm_pkg::GREEN_MIN_CYC,
    parameter longint HOLD_HALF_CYCLES = comfsm_pkg::HOLD_HALF_CYC,
    parameter longint PON_BLINK_CYCLES = comfsm_pkg::PON_BLINK_CYC,
    parameter longint FAST_HALF_CYCLES = comfsm_pkg::FAST_HALF_CYC
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response
    input wire logic run_req, // Run request pulse
    input wire logic stop_req, // Stop request pulse
    input wire logic watchdog_err, // Watchdog error pulse
    input wire logic warm_start_done, // Warm start routine finished
    input wire logic warm_start_err, // Warm start error, go stop
    input wire logic bkpt_hit, // Breakpoint reached in run
    input wire logic step_done, // Single statement executed
    output logic command_output_lock, // Outputs disabled
    output logic warm_start_routine, // Warm start invoke level
    output logic cyclic_main_routine, // Main routine enabled
    output logic output_image_clear, // Clear output image pulse
    output logic input_image_read, // Read input image pulse
    output logic program_timers_run, // Program timers/counters active
    output logic step_exec, // Execute one statement pulse
    output logic led_yellow, // Yellow status LED
    output logic led_green, // Green status LED
    output logic led_red, // Red status LED
    output logic [1:0] mode // Current mode
);
    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic rd_pend_ff;
    logic [7:0] rd_addr_ff;
    logic addr_ok;
    logic [1:0] bkpt_count_ff;
    logic cold_present_ff;
    logic wdog_latch_ff;
    logic step_rej_ff;
    logic [31:0] cycle_count_ff;
    comfsm_pkg::comfsm_mode_t mode_ff;
    logic cmd_run, cmd_stop, cmd_step, cmd_resume, cmd_ovr;
    logic led_yellow_ff, led_green_ff, led_red_ff;

    assign addr_ok = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rd_addr_ff <= 8'h00;
        end
        else
        begin
            wr_pend_ff <= addr_ok && hwrite;
            rd_pend_ff <= addr_ok && !hwrite;
            if (addr_ok)
            begin
                wr_addr_ff <= haddr[7:0];
                rd_addr_ff <= haddr[7:0];
            end
        end
    end

    logic wr_ctrl;
    assign wr_ctrl = wr_pend_ff && (wr_addr_ff == comfsm_pkg::ADDR_CTRL);
    assign cmd_run = (wr_ctrl && hwdata[comfsm_pkg::CTRL_RUN]) || run_req;
    assign cmd_stop = (wr_ctrl && hwdata[comfsm_pkg::CTRL_STOP]) || stop_req;
    assign cmd_step = (wr_ctrl && hwdata[comfsm_pkg::CTRL_STEP]);
    assign cmd_resume = (wr_ctrl && hwdata[comfsm_pkg::CTRL_RESUME]);
    assign cmd_ovr = (wr_ctrl && hwdata[comfsm_pkg::CTRL_OVERALL_RESET]);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cold_present_ff <= 1'b0;
            bkpt_count_ff <= 2'h0;
        end
        else
        begin
            if (wr_ctrl)
                cold_present_ff <= hwdata[comfsm_pkg::CTRL_COLD_PRESENT];
            // RULE_17 breakpoint count clamp
            if (wr_pend_ff && wr_addr_ff == comfsm_pkg::ADDR_BKPT)
                bkpt_count_ff <= (hwdata > 32'(comfsm_pkg::BKPT_MAX)) ?
                    2'(comfsm_pkg::BKPT_MAX) : hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (addr_ok && !hwrite)
        begin
            case (haddr[7:0])
                comfsm_pkg::ADDR_CTRL:
                    hrdata <= {26'h0, cold_present_ff, 5'h00};
                comfsm_pkg::ADDR_STATUS:
                    hrdata <= {23'h0, cold_present_ff, step_rej_ff, led_red_ff,
                        led_green_ff, led_yellow_ff, wdog_latch_ff,
                        command_output_lock, mode_ff};
                comfsm_pkg::ADDR_BKPT:
                    hrdata <= {30'h0, bkpt_count_ff};
                comfsm_pkg::ADDR_CYCLES:
                    hrdata <= cycle_count_ff;
                default:
                    hrdata <= 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Mode state machine
    // ****************************************************************
    logic step_allowed;
    // RULE_22 single step needs two or fewer
    assign step_allowed = bkpt_count_ff <= 2'(comfsm_pkg::BKPT_STEP_LIMIT);

    // RULE_12 watchdog latch, set wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wdog_latch_ff <= 1'b0;
        else if (watchdog_err)
            wdog_latch_ff <= 1'b1;
        // RULE_13 overall reset clears
        else if (cmd_ovr)
            wdog_latch_ff <= 1'b0;
        else if (mode_ff == comfsm_pkg::MODE_STARTUP && warm_start_done)
            wdog_latch_ff <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            step_rej_ff <= 1'b0;
        else if (mode_ff == comfsm_pkg::MODE_HOLD && cmd_step && !step_allowed)
            step_rej_ff <= 1'b1;
        else if (wr_ctrl || mode_ff != comfsm_pkg::MODE_HOLD)
            step_rej_ff <= 1'b0;
    end

    // RULE_01 four mode states
    // RULE_24 reset to stop, events only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mode_ff <= comfsm_pkg::MODE_STOP;
        else if (watchdog_err || cmd_stop)
            mode_ff <= comfsm_pkg::MODE_STOP;
        else
        begin
            case (mode_ff)
                comfsm_pkg::MODE_STOP:
                    // RULE_07 run goes via startup
                    if (cmd_run && (!wdog_latch_ff || cold_present_ff))
                        mode_ff <= comfsm_pkg::MODE_STARTUP;
                // RULE_08 no time supervision here
                comfsm_pkg::MODE_STARTUP:
                    if (warm_start_err)
                        mode_ff <= comfsm_pkg::MODE_STOP;
                    else if (warm_start_done)
                        mode_ff <= comfsm_pkg::MODE_RUN;
                comfsm_pkg::MODE_RUN:
                    // RULE_18 breakpoint enters hold
                    if (bkpt_hit && bkpt_count_ff != 2'h0)
                        mode_ff <= comfsm_pkg::MODE_HOLD;
                comfsm_pkg::MODE_HOLD:
                    if (cmd_resume)
                        mode_ff <= comfsm_pkg::MODE_RUN;
                default:
                    mode_ff <= comfsm_pkg::MODE_STOP;
            endcase
        end
    end

    // ****************************************************************
    // Program sequencing
    // ****************************************************************
    logic run_enter;
    logic step_ff;
    logic step_busy_ff;
    assign run_enter = mode_ff == comfsm_pkg::MODE_STARTUP && warm_start_done
        && !warm_start_err && !watchdog_err && !cmd_stop;

    // RULE_23 clear outputs then read inputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            output_image_clear <= 1'b0;
            input_image_read <= 1'b0;
        end
        else
        begin
            output_image_clear <= run_enter;
            input_image_read <= output_image_clear;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            step_ff <= 1'b0;
            step_busy_ff <= 1'b0;
        end
        else
        begin
            // RULE_18 one step per request
            step_ff <= mode_ff == comfsm_pkg::MODE_HOLD && cmd_step
                && step_allowed && !step_busy_ff;
            if (step_ff)
                step_busy_ff <= 1'b1;
            else if (step_done || mode_ff != comfsm_pkg::MODE_HOLD)
                step_busy_ff <= 1'b0;
        end
    end
    assign step_exec = step_ff;

    // RULE_14 count main routine passes
    // One pass per clock in run; there is no end-of-pass input to count on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cycle_count_ff <= 32'h00000000;
        else if (mode_ff == comfsm_pkg::MODE_RUN)
            cycle_count_ff <= cycle_count_ff + 32'h00000001;
    end

    // RULE_02 sequencer idle in stop
    // RULE_20 hold freezes program levels
    assign cyclic_main_routine = mode_ff == comfsm_pkg::MODE_RUN;
    assign warm_start_routine = mode_ff == comfsm_pkg::MODE_STARTUP;
    // RULE_15 timers active only in run
    // RULE_03 nothing cleared entering stop
    assign program_timers_run = mode_ff == comfsm_pkg::MODE_RUN;
    // RULE_04 lock in stop
    // RULE_09 lock in startup
    // RULE_16 unlock in run
    // RULE_21 lock in hold, links untouched
    assign command_output_lock = mode_ff != comfsm_pkg::MODE_RUN;
    assign mode = mode_ff;

    // ****************************************************************
    // Status LEDs
    // ****************************************************************
    logic [31:0] pon_cnt_ff;
    logic [31:0] fast_cnt_ff;
    logic fast_ph_ff;
    logic [31:0] green_cnt_ff;
    logic [31:0] hold_cnt_ff;
    logic hold_ph_ff;

    // RULE_06 power-on blink window
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pon_cnt_ff <= 32'h00000000;
            fast_cnt_ff <= 32'h00000000;
            fast_ph_ff <= 1'b0;
        end
        else
        begin
            if (pon_cnt_ff < 32'(PON_BLINK_CYCLES))
                pon_cnt_ff <= pon_cnt_ff + 32'h00000001;
            if (fast_cnt_ff >= 32'(FAST_HALF_CYCLES - 1))
            begin
                fast_cnt_ff <= 32'h00000000;
                fast_ph_ff <= !fast_ph_ff;
            end
            else
                fast_cnt_ff <= fast_cnt_ff + 32'h00000001;
        end
    end

    // RULE_10 green blink minimum window
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            green_cnt_ff <= 32'h00000000;
        else if (mode_ff == comfsm_pkg::MODE_STOP && cmd_run
            && (!wdog_latch_ff || cold_present_ff) && !watchdog_err && !cmd_stop)
            green_cnt_ff <= 32'(GREEN_MIN_CYCLES);
        else if (green_cnt_ff != 32'h00000000)
            green_cnt_ff <= green_cnt_ff - 32'h00000001;
    end

    // RULE_19 one hertz hold blink
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hold_cnt_ff <= 32'h00000000;
            hold_ph_ff <= 1'b0;
        end
        else if (hold_cnt_ff >= 32'(HOLD_HALF_CYCLES - 1))
        begin
            hold_cnt_ff <= 32'h00000000;
            hold_ph_ff <= !hold_ph_ff;
        end
        else
            hold_cnt_ff <= hold_cnt_ff + 32'h00000001;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            led_yellow_ff <= 1'b0;
            led_green_ff <= 1'b0;
            led_red_ff <= 1'b0;
        end
        else
        begin
            // RULE_05 yellow steady in stop
            led_yellow_ff <= mode_ff == comfsm_pkg::MODE_STOP &&
                (pon_cnt_ff >= 32'(PON_BLINK_CYCLES) || fast_ph_ff);
            led_red_ff <= mode_ff == comfsm_pkg::MODE_HOLD;
            if (mode_ff == comfsm_pkg::MODE_HOLD)
                led_green_ff <= hold_ph_ff;
            else if (green_cnt_ff != 32'h00000000 || mode_ff == comfsm_pkg::MODE_STARTUP)
                led_green_ff <= fast_ph_ff;
            else
                // RULE_11 green steady in run
                led_green_ff <= mode_ff == comfsm_pkg::MODE_RUN;
        end
    end
    assign led_yellow = led_yellow_ff;
    assign led_green = led_green_ff;
    assign led_red = led_red_ff;
endmodule : comfsm_top

// *** comfsm_asserts.sv ***
`timescale 1ns/10ps
module comfsm_asserts (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset
    input wire logic watchdog_err, // Watchdog
    input wire logic command_output_lock, // Lock
    input wire logic warm_start_routine, // Startup
    input wire logic cyclic_main_routine, // Main
    input wire logic program_timers_run, // Timers
    input wire logic output_image_clear, // Clear
    input wire logic input_image_read, // Read
    input wire logic step_exec, // Step
    input wire logic led_red, // Red
    input wire logic [1:0] mode // Mode
);
    // ****************
    // Mode properties
    // ****************
    default clocking dclk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_LOCK_OUTSIDE_RUN: assert property (mode != 2'h2 |-> command_output_lock)
        else $error("Lock low outside run");
    AST_LOCK_IN_RUN: assert property (mode == 2'h2 |-> !command_output_lock)
        else $error("Lock high in run");
    AST_WARM_LEVEL: assert property (warm_start_routine == (mode == 2'h1))
        else $error("Warm start level wrong");
    AST_RUN_ACTIVE: assert property (mode == 2'h2 |-> cyclic_main_routine && program_timers_run)
        else $error("Run not active");
    AST_IDLE_NOT_RUN: assert property (mode != 2'h2 |-> !cyclic_main_routine && !program_timers_run)
        else $error("Program active outside run");
    AST_WDOG_STOP: assert property (watchdog_err |=> mode == 2'h0)
        else $error("Watchdog did not stop");
    AST_RED_HOLD: assert property (mode == 2'h3 [*2] |-> led_red)
        else $error("Red off in hold");
    AST_STEP_IN_HOLD: assert property (step_exec |-> $past(mode) == 2'h3)
        else $error("Step outside hold");
    AST_STARTUP_FROM_STOP: assert property ($changed(mode) && mode == 2'h1 |-> $past(mode) == 2'h0)
        else $error("Startup not from stop");
    AST_HOLD_FROM_RUN: assert property ($changed(mode) && mode == 2'h3 |-> $past(mode) == 2'h2)
        else $error("Hold not from run");
    AST_IMAGE_ORDER: assert property ($past(mode) == 2'h1 && mode == 2'h2 |->
        ##[0:2] output_image_clear ##1 input_image_read)
        else $error("Image sequence wrong");

    cover property (mode == 2'h3 && step_exec);
    cover property ($past(mode) == 2'h1 && mode == 2'h2);
    cover property ($past(watchdog_err) && $past(mode) == 2'h2);
endmodule : comfsm_asserts

bind comfsm_top comfsm_asserts u_asserts (
    .hclk, .hresetn, .watchdog_err, .command_output_lock, .warm_start_routine,
    .cyclic_main_routine, .program_timers_run, .output_image_clear, .input_image_read,
    .step_exec, .led_red, .mode
);

// *** comfsm_prog_model.sv ***
`timescale 1ns/10ps
module comfsm_prog_model (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset
    input wire logic warm_start_routine, // Startup level
    input wire logic step_exec, // Step command
    input wire logic [7:0] ws_len, // Warm start length
    input wire logic ws_fail, // End in error
    output logic warm_start_done, // Done pulse
    output logic warm_start_err, // Error pulse
    output logic step_done // Statement done
);
    logic [7:0] cnt_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_ff <= 8'h00;
            warm_start_done <= 1'b0;
            warm_start_err <= 1'b0;
        end
        else
        begin
            cnt_ff <= warm_start_routine ? cnt_ff + 8'h01 : 8'h00;
            warm_start_done <= warm_start_routine && !ws_fail && cnt_ff == ws_len;
            warm_start_err <= warm_start_routine && ws_fail && cnt_ff == ws_len;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            step_done <= 1'b0;
        else
            step_done <= step_exec;
    end
endmodule : comfsm_prog_model

// *** test_comfsm_top.sv ***
`timescale 1ns/10ps
module test_comfsm_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ws_done, ws_err, step_done;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans, mode;
    logic [2:0] hsize, leds;
    logic run_req, stop_req, watchdog_err, bkpt_hit, lock, ws_run, main_run;
    logic img_clr, img_rd, tmr_run, step_exec, ws_fail;
    logic [7:0] ws_len;
    int bad_count = 0;
    int num_checks = 0;
    int t;

    comfsm_top #(.GREEN_MIN_CYCLES(50), .HOLD_HALF_CYCLES(10), .PON_BLINK_CYCLES(40),
        .FAST_HALF_CYCLES(4)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .run_req(run_req),
        .stop_req(stop_req), .watchdog_err(watchdog_err), .warm_start_done(ws_done),
        .warm_start_err(ws_err), .bkpt_hit(bkpt_hit), .step_done(step_done),
        .command_output_lock(lock), .warm_start_routine(ws_run),
        .cyclic_main_routine(main_run), .output_image_clear(img_clr),
        .input_image_read(img_rd), .program_timers_run(tmr_run), .step_exec(step_exec),
        .led_yellow(leds[0]), .led_green(leds[1]), .led_red(leds[2]), .mode(mode));

    comfsm_prog_model prog (.hclk(hclk), .hresetn(hresetn), .warm_start_routine(ws_run),
        .step_exec(step_exec), .ws_len(ws_len), .ws_fail(ws_fail),
        .warm_start_done(ws_done), .warm_start_err(ws_err), .step_done(step_done));

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask : step

    // Bits: 0 run, 1 stop, 2 watchdog, 3 breakpoint hit
    task automatic pulse(input logic [3:0] m);
        {bkpt_hit, watchdog_err, stop_req, run_req} <= m;
        @(posedge hclk);
        {bkpt_hit, watchdog_err, stop_req, run_req} <= 4'h0;
    endtask : pulse

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask : xfer

    task automatic wait_mode(input logic [1:0] m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++)
            @(posedge hclk);
        chk("mode", m, mode);
    endtask : wait_mode

    task automatic blink(input int k, input int n);
        logic p;
        t = 0;
        p = leds[k];
        repeat (n)
        begin
            @(posedge hclk);
            if (leds[k] !== p)
                t++;
            p = leds[k];
        end
    endtask : blink

    task automatic test_done;
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // ****************
    // Scenarios
    // ****************
    task automatic t_power_on;
        blink(0, 36);
        chk("yellow blink", 1'b1, t >= 2);
        step(10);
        blink(0, 20);
        chk("yellow toggles", 0, t);
        xfer(8'h04, 1'b0, 32'h0);
        chk("status", 32'h14, rv);
        chk("okay resp", 1'b0, hresp);
        xfer(8'h10, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rv);
    endtask : t_power_on

    task automatic t_run;
        logic [31:0] c;
        xfer(8'h00, 1'b1, 32'h1);
        wait_mode(2'h1, 4);
        blink(1, 40);
        chk("green startup", 1'b1, t >= 2);
        chk("lock startup", 1'b1, lock);
        step(60);
        chk("long warm start", 2'h1, mode);
        wait_mode(2'h2, 40);
        step(52);
        chk("lock run", 1'b0, lock);
        blink(1, 10);
        chk("green toggles", 0, t);
        chk("green run", 1'b1, leds[1]);
        xfer(8'h0C, 1'b0, 32'h0);
        c = rv;
        step(20);
        xfer(8'h0C, 1'b0, 32'h0);
        chk("passes", 1'b1, rv > c);
        pulse(4'h2);
        wait_mode(2'h0, 4);
        xfer(8'h0C, 1'b0, 32'h0);
        c = rv;
        step(10);
        xfer(8'h0C, 1'b0, 32'h0);
        chk("retained", c, rv);
        chk("stop idle", 1'b0, main_run);
    endtask : t_run

    task automatic t_hold(input logic [31:0] bk);
        logic seen;
        xfer(8'h08, 1'b1, bk);
        xfer(8'h08, 1'b0, 32'h0);
        chk("bkpt count", bk, rv);
        pulse(4'h8);
        wait_mode(2'h3, 8);
        step(3);
        chk("red", 1'b1, leds[2]);
        chk("lock hold", 1'b1, lock);
        chk("timers", 1'b0, tmr_run);
        blink(1, 40);
        chk("green hold", 4, t);
        xfer(8'h00, 1'b1, 32'h4);
        seen = 1'b0;
        repeat (4)
        begin
            @(posedge hclk);
            seen = seen | step_exec;
        end
        chk("step", bk < 3, seen);
        xfer(8'h04, 1'b0, 32'h0);
        chk("step refused", bk > 2, rv[7]);
        chk("still hold", 2'h3, rv[1:0]);
        xfer(8'h00, 1'b1, 32'h8);
        wait_mode(2'h2, 8);
        step(60);
        chk("red run", 1'b0, leds[2]);
    endtask : t_hold

    task automatic t_watchdog;
        pulse(4'h4);
        wait_mode(2'h0, 4);
        xfer(8'h04, 1'b0, 32'h0);
        chk("latch", 1'b1, rv[3]);
        pulse(4'h1);
        step(6);
        chk("run refused", 2'h0, mode);
        // Cold-start presence is stored first; run is judged on the stored bit
        xfer(8'h00, 1'b1, 32'h20);
        xfer(8'h00, 1'b0, 32'h0);
        chk("cold present", 32'h20, rv);
        xfer(8'h00, 1'b1, 32'h21);
        wait_mode(2'h2, 12);
        xfer(8'h00, 1'b1, 32'h2);
        wait_mode(2'h0, 4);
        pulse(4'h4);
        wait_mode(2'h0, 4);
        xfer(8'h00, 1'b1, 32'h10);
        xfer(8'h04, 1'b0, 32'h0);
        chk("latch cleared", 1'b0, rv[3]);
        ws_fail <= 1'b1;
        pulse(4'h1);
        wait_mode(2'h1, 4);
        wait_mode(2'h0, 10);
        blink(1, 30);
        chk("green after error", 1'b1, t >= 2);
    endtask : t_watchdog

    initial
    begin
        #60000;
        bad_count++;
        test_done();
    end

    initial
    begin
        {hsel, hwrite, run_req, stop_req, watchdog_err, ws_fail, bkpt_hit} = 7'h00;
        haddr = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ws_len = 8'h78;
        hresetn = 1'b0;
        step(20);
        hresetn <= 1'b1;
        t_power_on();
        t_run();
        ws_len <= 8'h03;
        pulse(4'h1);
        wait_mode(2'h2, 12);
        step(60);
        t_hold(32'h1);
        t_hold(32'h3);
        t_watchdog();
        test_done();
    end
endmodule : test_comfsm_top
